// [src/ssc_pkg.sv]
// Constants, command codes and carrier types of the scan sequence controller
// Summary of operation
// - Selecting a configuration generates at most 624 patterns, in groups of 24.
// - A repeat-count command overrides the configured number of repetitions.
// - Start argument 0x1 saves the result to the card; 0x0 does not.
// - Start raises projector power first, then the lamp, capturing lamp start time.
// - After the lamps, wake the ADC, then read humidity and temperature.
// - Hold off further power-up until 100 ms after lamp start.
// - Then enable video, set display for 24-bit RGB, read second temperature sensor.
// - Wait until 625 ms from lamp start, then read the photodetector.
// - A quick scan picks the highest gain that does not saturate the ADC.
// - Stream patterns, average several ADC samples each, repeat the set per repetition.
// - Each video frame carries 24 patterns.
// - Frame and pattern triggers track shown patterns, 24-pattern groups, buffer reloads.
// - ADC values are read only when data-ready flags a finished conversion.
// - At the end: sensors, lamp off, projector off, then header and values.
// - Status byte bit 1 is set during a scan, cleared when it completes.
// - Transfer-size on the result file gives the byte count; data commands return it.
// - Only one serial mode at a time: console log or command interface.
package ssc_pkg;
  localparam int unsigned CLK_HZ         = 125_000_000;
  localparam int unsigned LAMP_SURGE_MS  = 100;
  localparam int unsigned LAMP_STABLE_MS = 625;
  localparam int unsigned OVERHEAD_MS    = 100;
  localparam int unsigned SURGE_CYCLES   = LAMP_SURGE_MS * (CLK_HZ / 1000);
  localparam int unsigned STABLE_CYCLES  = LAMP_STABLE_MS * (CLK_HZ / 1000);
  localparam int unsigned MAX_PATTERNS   = 624;
  localparam int unsigned GROUP_PATTERNS = 24;

  localparam logic [7:0] OFS_CMD    = 8'h00;
  localparam logic [7:0] OFS_RESP   = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_MODE   = 8'h0C;
  localparam logic [7:0] OFS_GAIN   = 8'h10;

  localparam logic [7:0] OP_APPLY_CFG  = 8'h01;
  localparam logic [7:0] OP_SELECT_CFG = 8'h02;
  localparam logic [7:0] OP_REPEAT     = 8'h03;
  localparam logic [7:0] OP_DURATION   = 8'h04;
  localparam logic [7:0] OP_START      = 8'h05;
  localparam logic [7:0] OP_STATUS     = 8'h06;
  localparam logic [7:0] OP_XFER_SIZE  = 8'h07;
  localparam logic [7:0] OP_XFER_DATA  = 8'h08;

  localparam int unsigned CMD_ARG_LSB     = 8;
  localparam int unsigned CFG_REP_LSB     = 10;
  localparam logic [15:0] RESULT_FILE_SEL = 16'h0002;
  localparam logic [7:0]  SAVE_ON         = 8'h01;
  localparam logic [7:0]  SAVE_OFF        = 8'h00;

  localparam int unsigned ST_PATGEN_BIT = 0;
  localparam int unsigned ST_ACTIVE_BIT = 1;
  localparam int unsigned ST_CFG_BIT    = 2;

  localparam logic       MODE_RESET = 1'b1;
  localparam logic [2:0] GAIN_MAX   = 3'h7;
  localparam logic [23:0] ADC_SAT   = 24'hFFFF00;

  typedef enum logic [2:0] {
    STEP_ADC_WAKE, STEP_HUM_TEMP, STEP_DISP_RGB24, STEP_TEMP2,
    STEP_PHOTO, STEP_DISP_STREAM, STEP_END_SENSORS
  } ssc_step_code_t;

  typedef struct packed {
    logic           valid;
    ssc_step_code_t code;
  } ssc_step_t;

  typedef struct packed {
    logic [9:0] patterns;
    logic [7:0] repeats;
  } ssc_cfg_t;
endpackage

// [src/ssc_scan_ctrl.sv]
// Scan sequence controller: APB command port, power-up sequence, pattern scan, result readout
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/1ps
module ssc_scan_ctrl
  import ssc_pkg::*;
#(
  parameter int unsigned SURGE_CYC     = SURGE_CYCLES,
  parameter int unsigned STABLE_CYC    = STABLE_CYCLES,
  parameter int unsigned SAMPLES_LOG2  = 2,
  parameter int unsigned QUICK_SAMPLES = 8,
  parameter int unsigned PATTERN_MS    = 1
) (
  input  wire logic        CLK,
  input  wire logic        RSTN,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  output logic             SERIAL_CMD_MODE,
  output logic             PATGEN_START,
  output logic [9:0]       PATGEN_COUNT,
  input  wire logic        PATGEN_DONE,
  output logic             PROJ_PWR_EN,
  output logic             LAMP_EN,
  output logic             VIDEO_EN,
  output ssc_step_t        STEP,
  input  wire logic        STEP_DONE,
  output logic             STREAM_EN,
  output logic             BUF_RELOAD,
  input  wire logic        FRAME_TRIGGER_IN,
  input  wire logic        PATTERN_TRIGGER_IN,
  input  wire logic        ADC_DATA_READY,
  input  wire logic [23:0] ADC_DATA,
  output logic [2:0]       ADC_GAIN_AMP,
  output logic             SAVE_REQ
);
  localparam int unsigned SAMPLES = 1 << SAMPLES_LOG2;
  localparam int unsigned SW      = SAMPLES_LOG2 + 4;

  typedef enum logic [4:0] {
    ST_IDLE, ST_PROJ_UP, ST_LAMP_ON, ST_ADC_WAKE, ST_HUM_TEMP, ST_SURGE_WAIT,
    ST_VIDEO_CFG, ST_TEMP2, ST_STABLE_WAIT, ST_PHOTO, ST_STREAM_CFG, ST_QUICK,
    ST_SCAN, ST_END_SENSORS, ST_LAMP_OFF, ST_PROJ_OFF, ST_HEADER
  } ssc_state_t;

  ssc_state_t        state, next_state;
  ssc_cfg_t          cfg, next_cfg;
  logic              cfg_valid, next_cfg_valid;
  logic              patgen_busy, next_patgen_busy;
  logic              mode, next_mode;
  logic [31:0]       resp, next_resp;
  logic [31:0]       timer, lamp_start, next_lamp_start;
  logic              step_issued, next_step_issued;
  logic              save_flag, next_save_flag;
  logic              result_valid, next_result_valid;
  logic              xfer_armed, next_xfer_armed;
  logic [9:0]        rd_ptr, next_rd_ptr;
  logic [9:0]        pat_idx, next_pat_idx;
  logic [7:0]        rep_cnt, next_rep_cnt;
  logic [4:0]        frame_cnt, next_frame_cnt;
  logic              shown, next_shown;
  logic [SW-1:0]     samp_cnt, next_samp_cnt;
  logic [25+SW:0]    acc, next_acc;
  logic [2:0]        gain, next_gain;
  logic              next_patgen_start, next_proj, next_lamp, next_video, next_stream;
  logic              next_reload, next_save_req;
  logic [9:0]        next_patgen_count;
  ssc_step_t         next_step;
  logic              mem_we;
  logic [9:0]        mem_addr;
  logic [31:0]       mem_wdata;
  logic [31:0]       result_mem [0:MAX_PATTERNS];

  logic              access, cmd_wr, scan_active, mapped, in_step;
  logic [7:0]        opcode, status_byte;
  logic [15:0]       arg;
  logic [31:0]       elapsed, avg, duration_ms;
  logic [9:0]        arg_pat;
  ssc_step_code_t    step_code;

  assign access      = PSEL && PENABLE;
  assign cmd_wr      = access && PWRITE && PADDR == OFS_CMD && mode;
  assign opcode      = PWDATA[7:0];
  assign arg         = PWDATA[CMD_ARG_LSB +: 16];
  assign scan_active = state != ST_IDLE;
  assign elapsed     = timer - lamp_start;
  // Last sample joins the sum before the divide, so truncation happens only once
  assign avg         = 32'((acc + (26 + SW)'(ADC_DATA)) >> SAMPLES_LOG2);
  assign arg_pat     = (32'(arg[9:0]) > MAX_PATTERNS) ? 10'(MAX_PATTERNS) : arg[9:0];
  assign duration_ms = 32'(LAMP_SURGE_MS + LAMP_STABLE_MS + OVERHEAD_MS)
                     + 32'(cfg.patterns) * 32'(cfg.repeats + 8'h01) * 32'(PATTERN_MS);
  assign status_byte = {5'h00, cfg_valid, scan_active, patgen_busy};

  // Zero wait states; unmapped offsets answer with an error
  assign mapped  = PADDR inside {OFS_CMD, OFS_RESP, OFS_STATUS, OFS_MODE, OFS_GAIN};
  assign PREADY  = 1'b1;
  assign PSLVERR = access && !mapped;

  always_comb begin
    unique case (PADDR)
      OFS_RESP:   PRDATA = resp;
      OFS_STATUS: PRDATA = {24'h000000, status_byte};
      OFS_MODE:   PRDATA = {31'h00000000, mode};
      OFS_GAIN:   PRDATA = {29'h00000000, gain};
      default:    PRDATA = 32'h00000000;
    endcase
  end

  always_comb begin
    in_step   = 1'b1;
    step_code = STEP_ADC_WAKE;
    unique case (state)
      ST_ADC_WAKE:    step_code = STEP_ADC_WAKE;
      ST_HUM_TEMP:    step_code = STEP_HUM_TEMP;
      ST_VIDEO_CFG:   step_code = STEP_DISP_RGB24;
      ST_TEMP2:       step_code = STEP_TEMP2;
      ST_PHOTO:       step_code = STEP_PHOTO;
      ST_STREAM_CFG:  step_code = STEP_DISP_STREAM;
      ST_END_SENSORS: step_code = STEP_END_SENSORS;
      default:        in_step = 1'b0;
    endcase
  end

  always_comb begin
    next_state = state;           next_cfg = cfg;             next_cfg_valid = cfg_valid;
    next_patgen_busy = patgen_busy; next_mode = mode;         next_resp = resp;
    next_lamp_start = lamp_start; next_step_issued = step_issued;
    next_save_flag = save_flag;   next_result_valid = result_valid;
    next_xfer_armed = xfer_armed; next_rd_ptr = rd_ptr;       next_pat_idx = pat_idx;
    next_rep_cnt = rep_cnt;       next_frame_cnt = frame_cnt; next_shown = shown;
    next_samp_cnt = samp_cnt;     next_acc = acc;             next_gain = gain;
    next_patgen_start = 1'b0;     next_patgen_count = PATGEN_COUNT;
    next_proj = PROJ_PWR_EN;      next_lamp = LAMP_EN;        next_video = VIDEO_EN;
    next_stream = STREAM_EN;      next_reload = 1'b0;         next_save_req = 1'b0;
    next_step = '{valid: 1'b0, code: STEP.code};
    mem_we = 1'b0;                mem_addr = 10'h000;         mem_wdata = 32'h00000000;

    if (access && PWRITE && PADDR == OFS_MODE && !scan_active) begin
      next_mode = PWDATA[0];
    end
    if (PATGEN_DONE && patgen_busy) begin
      next_patgen_busy = 1'b0;
      next_cfg_valid   = 1'b1;
    end

    if (cmd_wr) begin
      unique case (opcode)
        OP_APPLY_CFG, OP_SELECT_CFG: begin
          if (!scan_active && !patgen_busy && arg_pat != 10'h000) begin
            next_cfg          = '{patterns: arg_pat, repeats: {2'b00, arg[15:CFG_REP_LSB]}};
            next_cfg_valid    = 1'b0;
            next_patgen_busy  = 1'b1;
            next_patgen_start = 1'b1;
            next_patgen_count = arg_pat;
          end
        end
        OP_REPEAT: begin
          if (!scan_active) begin
            next_cfg.repeats = (arg[7:0] == 8'h00) ? 8'h00 : arg[7:0] - 8'h01;
          end
        end
        OP_DURATION: next_resp = duration_ms;
        OP_START: begin
          // A running scan is left alone; no configuration means nothing to show
          if (!scan_active && cfg_valid && !patgen_busy) begin
            next_state        = ST_PROJ_UP;
            next_save_flag    = arg[7:0] == SAVE_ON;
            next_result_valid = 1'b0;
            next_xfer_armed   = 1'b0;
          end
        end
        OP_STATUS: next_resp = {24'h000000, status_byte};
        OP_XFER_SIZE: begin
          next_xfer_armed = arg == RESULT_FILE_SEL && result_valid;
          next_rd_ptr     = 10'h000;
          next_resp       = next_xfer_armed ? 32'(({22'h000000, cfg.patterns} + 32'h1) << 2) : 32'h0;
        end
        OP_XFER_DATA: begin
          if (xfer_armed && rd_ptr <= cfg.patterns) begin
            next_resp   = result_mem[rd_ptr];
            next_rd_ptr = rd_ptr + 10'h001;
          end else begin
            next_resp = 32'h00000000;
          end
        end
        default: ;
      endcase
    end

    // Sensor and display steps share one request/done handshake
    if (in_step) begin
      if (!step_issued) begin
        next_step        = '{valid: 1'b1, code: step_code};
        next_step_issued = 1'b1;
      end else if (STEP_DONE) begin
        next_step_issued = 1'b0;
        unique case (state)
          ST_ADC_WAKE:    next_state = ST_HUM_TEMP;
          ST_HUM_TEMP:    next_state = ST_SURGE_WAIT;
          ST_VIDEO_CFG:   next_state = ST_TEMP2;
          ST_TEMP2:       next_state = ST_STABLE_WAIT;
          ST_PHOTO:       next_state = ST_STREAM_CFG;
          ST_STREAM_CFG:  next_state = ST_QUICK;
          default:        next_state = ST_LAMP_OFF;
        endcase
        if (state == ST_STREAM_CFG) begin
          next_gain      = GAIN_MAX;
          next_stream    = 1'b1;
          next_samp_cnt  = '0;
          next_frame_cnt = 5'h00;
          next_shown     = 1'b0;
        end
      end
    end

    // Frame and pattern triggers; a frame restarts the group of 24 unless a pattern trigger comes in the same cycle
    if (STREAM_EN) begin
      if (FRAME_TRIGGER_IN) next_frame_cnt = 5'h00;
      if (PATTERN_TRIGGER_IN) begin
        next_shown = 1'b1;
        if (frame_cnt == 5'(GROUP_PATTERNS - 1)) begin
          next_frame_cnt = 5'h00;
          next_reload    = 1'b1;
        end else begin
          next_frame_cnt = frame_cnt + 5'h01;
        end
      end
    end

    unique case (state)
      ST_PROJ_UP: begin
        next_proj  = 1'b1;
        next_state = ST_LAMP_ON;
      end
      ST_LAMP_ON: begin
        next_lamp       = 1'b1;
        next_lamp_start = timer;
        next_state      = ST_ADC_WAKE;
      end
      ST_SURGE_WAIT: begin
        if (elapsed >= 32'(SURGE_CYC)) begin
          next_state = ST_VIDEO_CFG;
          next_video = 1'b1;
        end
      end
      ST_STABLE_WAIT: if (elapsed >= 32'(STABLE_CYC)) next_state = ST_PHOTO;
      ST_QUICK: begin
        // Lower the gain on every saturated sample while gain is above 0; a clean run fixes it
        if (ADC_DATA_READY) begin
          if (ADC_DATA >= ADC_SAT && gain != 3'h0) begin
            next_gain     = gain - 3'h1;
            next_samp_cnt = '0;
          end else if (samp_cnt == SW'(QUICK_SAMPLES - 1)) begin
            next_samp_cnt = '0;
            next_acc      = '0;
            next_pat_idx  = 10'h000;
            next_rep_cnt  = 8'h00;
            next_shown    = 1'b0;
            next_state    = ST_SCAN;
          end else begin
            next_samp_cnt = samp_cnt + SW'(1);
          end
        end
      end
      ST_SCAN: begin
        if (shown && ADC_DATA_READY) begin
          if (samp_cnt == SW'(SAMPLES - 1)) begin
            mem_we        = 1'b1;
            mem_addr      = pat_idx + 10'h001;
            mem_wdata     = (rep_cnt == 8'h00) ? avg : result_mem[mem_addr] + avg;
            next_samp_cnt = '0;
            next_acc      = '0;
            next_shown    = PATTERN_TRIGGER_IN;
            if (pat_idx == cfg.patterns - 10'h001) begin
              next_pat_idx = 10'h000;
              if (rep_cnt == cfg.repeats) begin
                next_state  = ST_END_SENSORS;
                next_stream = 1'b0;
              end else begin
                next_rep_cnt = rep_cnt + 8'h01;
              end
            end else begin
              next_pat_idx = pat_idx + 10'h001;
            end
          end else begin
            next_samp_cnt = samp_cnt + SW'(1);
          end
        end
        if (shown && ADC_DATA_READY) next_acc = (samp_cnt == SW'(SAMPLES - 1)) ? '0 : acc + (26 + SW)'(ADC_DATA);
      end
      ST_LAMP_OFF: begin
        next_lamp  = 1'b0;
        next_video = 1'b0;
        next_state = ST_PROJ_OFF;
      end
      ST_PROJ_OFF: begin
        next_proj  = 1'b0;
        next_state = ST_HEADER;
      end
      ST_HEADER: begin
        mem_we            = 1'b1;
        mem_addr          = 10'h000;
        mem_wdata         = {cfg.repeats, 5'h00, gain, 6'h00, cfg.patterns};
        next_result_valid = 1'b1;
        next_save_req     = save_flag;
        next_state        = ST_IDLE;
      end
      default: ;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (mem_we) result_mem[mem_addr] <= mem_wdata;
  end

  always_ff @(posedge CLK) begin
    if (!RSTN) begin
      state <= ST_IDLE;        cfg <= '0;             cfg_valid <= 1'b0;
      patgen_busy <= 1'b0;     mode <= MODE_RESET;    resp <= 32'h00000000;
      timer <= 32'h00000000;   lamp_start <= 32'h00000000;
      step_issued <= 1'b0;     save_flag <= 1'b0;     result_valid <= 1'b0;
      xfer_armed <= 1'b0;      rd_ptr <= 10'h000;     pat_idx <= 10'h000;
      rep_cnt <= 8'h00;        frame_cnt <= 5'h00;    shown <= 1'b0;
      samp_cnt <= '0;          acc <= '0;             gain <= GAIN_MAX;
      PATGEN_START <= 1'b0;    PATGEN_COUNT <= 10'h000;
      PROJ_PWR_EN <= 1'b0;     LAMP_EN <= 1'b0;       VIDEO_EN <= 1'b0;
      STEP <= '0;              STREAM_EN <= 1'b0;     BUF_RELOAD <= 1'b0;
      SAVE_REQ <= 1'b0;
    end else begin
      state <= next_state;     cfg <= next_cfg;       cfg_valid <= next_cfg_valid;
      patgen_busy <= next_patgen_busy; mode <= next_mode; resp <= next_resp;
      timer <= timer + 32'h00000001; lamp_start <= next_lamp_start;
      step_issued <= next_step_issued; save_flag <= next_save_flag;
      result_valid <= next_result_valid; xfer_armed <= next_xfer_armed;
      rd_ptr <= next_rd_ptr;   pat_idx <= next_pat_idx; rep_cnt <= next_rep_cnt;
      frame_cnt <= next_frame_cnt; shown <= next_shown; samp_cnt <= next_samp_cnt;
      acc <= next_acc;         gain <= next_gain;
      PATGEN_START <= next_patgen_start; PATGEN_COUNT <= next_patgen_count;
      PROJ_PWR_EN <= next_proj; LAMP_EN <= next_lamp; VIDEO_EN <= next_video;
      STEP <= next_step;       STREAM_EN <= next_stream; BUF_RELOAD <= next_reload;
      SAVE_REQ <= next_save_req;
    end
  end

  assign SERIAL_CMD_MODE = mode;
  assign ADC_GAIN_AMP    = gain;

  default clocking ssc_cb @(posedge CLK); endclocking
  default disable iff (!RSTN);

  a_start_ignored: assert property (cmd_wr && opcode == OP_START && scan_active |=> state != ST_PROJ_UP)
    else $error("start accepted during a running scan");
  a_lamp_after_proj: assert property ($rose(LAMP_EN) |-> PROJ_PWR_EN && $past(PROJ_PWR_EN))
    else $error("lamp enabled before projector power");
  a_surge_hold: assert property ($past(state) == ST_SURGE_WAIT && state == ST_VIDEO_CFG
                                 |-> $past(elapsed) >= 32'(SURGE_CYC))
    else $error("power-up resumed before the surge wait ended");
  a_stable_hold: assert property ($past(state) == ST_STABLE_WAIT && state == ST_PHOTO
                                  |-> $past(elapsed) >= 32'(STABLE_CYC))
    else $error("photodetector read before lamp stabilisation");
  a_proj_off_last: assert property ($fell(PROJ_PWR_EN) |-> !LAMP_EN && !VIDEO_EN)
    else $error("projector power dropped with lamp still on");
  a_sample_on_adc_data_ready: assert property (state == ST_SCAN && samp_cnt != $past(samp_cnt) |-> $past(ADC_DATA_READY))
    else $error("ADC sample taken without data ready");
  a_reload_group: assert property (BUF_RELOAD |-> $past(PATTERN_TRIGGER_IN)
                                   && $past(frame_cnt) == 5'(GROUP_PATTERNS - 1))
    else $error("buffer reload not at the end of a 24-pattern group");
  a_console_mode: assert property (access && PWRITE && PADDR == OFS_CMD && !mode
                                   |=> $stable(resp) && $stable(cfg) && $stable(state) || state != $past(state)
                                   && $past(state) != ST_IDLE)
    else $error("command taken while in console mode");
  a_status_busy: assert property (cmd_wr && opcode == OP_START && !scan_active && cfg_valid && !patgen_busy
                                  |=> status_byte[ST_ACTIVE_BIT] ##1 PROJ_PWR_EN)
    else $error("scan active bit not set after start");
  a_save_request: assert property (state == ST_HEADER |=> SAVE_REQ == $past(save_flag) && result_valid)
    else $error("save request does not follow the start argument");
  a_patgen_limit: assert property (PATGEN_START |-> PATGEN_COUNT != 10'h000
                                   && 32'(PATGEN_COUNT) <= MAX_PATTERNS)
    else $error("pattern count out of range");

  c_full_scan:    cover property (state == ST_HEADER ##1 state == ST_IDLE);
  c_gain_lowered: cover property (state == ST_QUICK && gain != $past(gain));
  c_reload:       cover property (BUF_RELOAD);
  c_start_busy:   cover property (cmd_wr && opcode == OP_START && scan_active);
endmodule

// [sim/ssc_periph_model.sv]
// Far-side model: pattern generator, step executor, display triggers and ADC
`timescale 1ns/1ps
module ssc_periph_model
  import ssc_pkg::*;
#(
  parameter logic [23:0] LEVEL = 24'h001234
) (
  input  wire logic        CLK,
  input  wire logic        PATGEN_START,
  input  wire ssc_step_t   STEP,
  input  wire logic        STREAM_EN,
  input  wire logic [2:0]  ADC_GAIN_AMP,
  output logic             PATGEN_DONE,
  output logic             STEP_DONE,
  output logic             FRAME_TRIGGER_IN,
  output logic             PATTERN_TRIGGER_IN,
  output logic             ADC_DATA_READY,
  output logic [23:0]      ADC_DATA
);
  int unsigned cnt;
  logic [3:0]  step_dly;
  initial begin
    {PATGEN_DONE, STEP_DONE, FRAME_TRIGGER_IN, PATTERN_TRIGGER_IN, ADC_DATA_READY} = '0;
    ADC_DATA = 24'h0;
    cnt = 0;
    step_dly = 4'h0;
  end
  // Gains above 3 saturate, so the gain search must settle on 3
  always @(posedge CLK) begin
    cnt <= STREAM_EN ? cnt + 1 : 0;
    PATGEN_DONE <= PATGEN_START;
    step_dly <= {step_dly[2:0], STEP.valid};
    STEP_DONE <= step_dly[3];
    PATTERN_TRIGGER_IN <= STREAM_EN && (cnt % 16 == 1);
    FRAME_TRIGGER_IN <= STREAM_EN && (cnt % 384 == 1);
    ADC_DATA_READY <= STREAM_EN && (cnt % 3 == 0);
    // Outside a conversion the data lines toggle so stale values never look valid
    ADC_DATA <= (STREAM_EN && cnt % 3 == 0) ? ((ADC_GAIN_AMP > 3'h3) ? 24'hFFFFF0 : LEVEL) : ~ADC_DATA;
  end
endmodule

// [sim/scan_sequence_controller_tb_top.sv]
// Self-checking bench: host commands over APB, scan result checks
`timescale 1ns/1ps
module scan_sequence_controller_tb_top;
  import ssc_pkg::*;
  localparam int unsigned SURGE  = 20;
  localparam int unsigned STABLE = 60;
  // Not a multiple of the sample count, so a split truncation would show
  localparam int unsigned LEVEL  = 32'h1235;
  logic        CLK, RSTN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, SERIAL_CMD_MODE, PATGEN_START, PATGEN_DONE;
  logic        PROJ_PWR_EN, LAMP_EN, VIDEO_EN, STEP_DONE, STREAM_EN, BUF_RELOAD, FRAME_TRIGGER_IN;
  logic        PATTERN_TRIGGER_IN, ADC_DATA_READY, SAVE_REQ, rerr, pwr_ok;
  logic [7:0]  PADDR;
  logic [31:0] PWDATA, PRDATA, rdata;
  logic [9:0]  PATGEN_COUNT;
  logic [23:0] ADC_DATA;
  logic [2:0]  ADC_GAIN_AMP;
  ssc_step_t   STEP;
  ssc_step_code_t steps[$];
  int          n_errors, num_checks, p, saves, lamp_cnt, vid_at, photo_at, trigs, reloads;

  ssc_scan_ctrl #(.SURGE_CYC(SURGE), .STABLE_CYC(STABLE)) DUT (
    .CLK(CLK), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .SERIAL_CMD_MODE(SERIAL_CMD_MODE),
    .PATGEN_START(PATGEN_START), .PATGEN_COUNT(PATGEN_COUNT), .PATGEN_DONE(PATGEN_DONE),
    .PROJ_PWR_EN(PROJ_PWR_EN), .LAMP_EN(LAMP_EN), .VIDEO_EN(VIDEO_EN), .STEP(STEP), .STEP_DONE(STEP_DONE),
    .STREAM_EN(STREAM_EN), .BUF_RELOAD(BUF_RELOAD), .FRAME_TRIGGER_IN(FRAME_TRIGGER_IN),
    .PATTERN_TRIGGER_IN(PATTERN_TRIGGER_IN), .ADC_DATA_READY(ADC_DATA_READY), .ADC_DATA(ADC_DATA),
    .ADC_GAIN_AMP(ADC_GAIN_AMP), .SAVE_REQ(SAVE_REQ));
  ssc_periph_model #(.LEVEL(LEVEL[23:0])) MODEL (
    .CLK(CLK), .PATGEN_START(PATGEN_START), .STEP(STEP), .STREAM_EN(STREAM_EN), .ADC_GAIN_AMP(ADC_GAIN_AMP),
    .PATGEN_DONE(PATGEN_DONE), .STEP_DONE(STEP_DONE), .FRAME_TRIGGER_IN(FRAME_TRIGGER_IN),
    .PATTERN_TRIGGER_IN(PATTERN_TRIGGER_IN), .ADC_DATA_READY(ADC_DATA_READY), .ADC_DATA(ADC_DATA));

  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  // Lamp must never be on without projector power, both at power-up and power-down
  always @(posedge CLK) begin
    if (STEP.valid === 1'b1) steps.push_back(STEP.code);
    if (STEP.valid === 1'b1 && STEP.code === STEP_PHOTO) photo_at = lamp_cnt;
    if (SAVE_REQ === 1'b1) saves++;
    if (STREAM_EN === 1'b1 && PATTERN_TRIGGER_IN === 1'b1) trigs++;
    if (BUF_RELOAD === 1'b1) reloads++;
    if (VIDEO_EN === 1'b1 && vid_at == 0) vid_at = lamp_cnt;
    if (LAMP_EN === 1'b1 && PROJ_PWR_EN !== 1'b1) pwr_ok = 1'b0;
    lamp_cnt <= (LAMP_EN === 1'b1) ? lamp_cnt + 1 : 0;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    do @(posedge CLK); while (PREADY !== 1'b1);
    rdata = PRDATA;
    rerr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic cmd(input logic [7:0] op, input logic [15:0] arg, input logic rd);
    apb(1'b1, OFS_CMD, {8'h00, arg, op});
    if (rd) apb(1'b0, OFS_RESP, 32'h0);
  endtask
  // Host side polls status; the watchdog bounds the wait like the duration timeout
  task automatic wait_st(input int b, input logic v);
    apb(1'b0, OFS_STATUS, 32'h0);
    while (rdata[b] !== v) apb(1'b0, OFS_STATUS, 32'h0);
  endtask
  task automatic scan(input logic [7:0] arg, input int n);
    steps = {};
    saves = 0;
    trigs = 0;
    reloads = 0;
    vid_at = 0;
    pwr_ok = 1'b1;
    cmd(OP_START, {8'h00, arg}, 1'b0);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("active", 32'h1, 32'(rdata[ST_ACTIVE_BIT]));
    cmd(OP_START, {8'h00, arg}, 1'b0);
    wait_st(ST_ACTIVE_BIT, 1'b0);
    // The save pulse of the closing edge reaches the monitor one edge later
    @(posedge CLK);
    chk("steps", 32'd7, 32'(steps.size()));
    foreach (steps[i]) chk("step code", 32'(i), 32'(steps[i]));
    chk("save", 32'(arg == 8'h01), 32'(saves));
    chk("power order", 32'h1, 32'(pwr_ok));
    chk("reloads", 32'(trigs / GROUP_PATTERNS), 32'(reloads));
    chk("surge wait", 32'h1, 32'(vid_at >= SURGE));
    chk("stable wait", 32'h1, 32'(photo_at >= STABLE));
    apb(1'b0, OFS_GAIN, 32'h0);
    chk("gain", 32'h3, rdata);
    cmd(OP_XFER_SIZE, 16'h0001, 1'b1);
    chk("size other file", 32'h0, rdata);
    cmd(OP_XFER_SIZE, RESULT_FILE_SEL, 1'b1);
    chk("size", 32'((p + 1) * 4), rdata);
    cmd(OP_XFER_DATA, 16'h0, 1'b1);
    chk("header", 32'(((n - 1) << 24) | (3 << 16) | p), rdata);
    for (int i = 0; i <= p; i++) begin
      cmd(OP_XFER_DATA, 16'h0, 1'b1);
      chk("word", (i < p) ? 32'(n * LEVEL) : 32'h0, rdata);
    end
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    // Several times the longest expected run of a few thousand cycles
    #100000;
    n_errors++;
    conclude();
  end
  initial begin
    {RSTN, PSEL, PENABLE, PWRITE, PADDR, PWDATA} = '0;
    {n_errors, num_checks, saves, lamp_cnt, vid_at, photo_at} = '0;
    void'($urandom(32'h4921));
    p = 25 + $urandom % 8;
    repeat (12) @(posedge CLK);
    RSTN <= 1'b1;
    apb(1'b0, OFS_GAIN, 32'h0);
    chk("gain reset", 32'h7, rdata);
    apb(1'b0, 8'h14, 32'h0);
    chk("unmapped", 32'h1, 32'(rerr));
    cmd(OP_START, 16'h1, 1'b0);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("start unconfigured", 32'h0, rdata);
    cmd(OP_APPLY_CFG, 16'd700, 1'b0);
    wait_st(ST_CFG_BIT, 1'b1);
    chk("clamp", 32'd624, 32'(PATGEN_COUNT));
    cmd(OP_SELECT_CFG, 16'(p), 1'b0);
    wait_st(ST_PATGEN_BIT, 1'b0);
    chk("count", 32'(p), 32'(PATGEN_COUNT));
    cmd(OP_REPEAT, 16'h2, 1'b0);
    cmd(OP_DURATION, 16'h0, 1'b1);
    chk("duration", 32'(825 + p * 2), rdata);
    scan(8'h01, 2);
    apb(1'b1, OFS_MODE, 32'h0);
    cmd(OP_START, 16'h0, 1'b0);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk("console mode", 32'h0, 32'({SERIAL_CMD_MODE, rdata[ST_ACTIVE_BIT]}));
    apb(1'b1, OFS_MODE, 32'h1);
    cmd(OP_STATUS, 16'h0, 1'b1);
    chk("status byte", 32'h4, rdata);
    cmd(OP_REPEAT, 16'h1, 1'b0);
    scan(8'h00, 1);
    conclude();
  end
endmodule
